// ==== e1ra_alarm_detector.sv ====
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "e1ra_defines.svh"

module e1ra_alarm_detector
	import e1ra_pkg::*;
#(
	parameter int unsigned RED_CYCLES = 32'(`E1RA_RED_CYCLES)
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire e1ra_rx_t rx_in,
	input wire logic other_irq,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_n
);

	// Refuse a persistence count the counter cannot hold
	generate
		if (RED_CYCLES < 1 || RED_CYCLES > 24'hFFFFFF) begin : g_bad
			$error("RED_CYCLES out of range");
		end
	endgenerate

	localparam logic [23:0] RED_LAST = 24'(RED_CYCLES - 1);

	e1ra_alarm_t state_reg; // Live alarm states
	e1ra_alarm_t prev_reg; // States one cycle ago
	logic [5:0] flags_reg; // Sticky change flags
	logic [5:0] irq_en_reg; // Interrupt enables
	logic allones_crit_reg; // All-ones criterion select
	logic remote_crit_reg; // Remote criterion select

	// Bus decode
	logic [9:0] idx; // Register index
	logic bus_req; // Fresh request this cycle
	logic wr_lo; // Lane 0 write, lands with the acknowledge
	logic [5:0] flag_clear; // Write-one clear mask
	logic [7:0] rd_byte; // Read mux result

	assign idx = wb_adr_i[11:2];
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// Write lands on the edge that sees ack, as the master does
	assign wr_lo = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];

	// Clear mask from a write to the flag register
	always_comb begin
		if (wr_lo && idx == `E1RA_IDX_FLAGS) begin
			flag_clear = wb_dat_i[5:0];
		end else begin
			flag_clear = 6'h00;
		end
	end

	// Zeros in one slot-16 octet
	function automatic logic [3:0] zeros8(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, ~v[i]};
		end
		return n;
	endfunction

	// Slot-16 loss
	logic [4:0] zrun_reg; // Consecutive all-zero octets
	logic [4:0] nzrun_reg; // Consecutive nonzero octets

	// Runs of zero and nonzero octets
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			zrun_reg <= 5'h00;
			nzrun_reg <= 5'h00;
			state_reg.slot16_loss <= 1'b0;
		end else if (rx_in.basic_aligned && rx_in.slot16_valid) begin
			if (rx_in.slot16_octet == 8'h00) begin
				nzrun_reg <= 5'h00;
				if (zrun_reg != `E1RA_SLOT16_RUN) begin
					zrun_reg <= zrun_reg + 5'h01;
				end
				if (zrun_reg == `E1RA_SLOT16_RUN - 5'h01) begin
					state_reg.slot16_loss <= 1'b1;
				end
			end else begin
				zrun_reg <= 5'h00;
				if (nzrun_reg != `E1RA_SLOT16_RUN) begin
					nzrun_reg <= nzrun_reg + 5'h01;
				end
				if (nzrun_reg == `E1RA_SLOT16_RUN - 5'h01) begin
					state_reg.slot16_loss <= 1'b0;
				end
			end
		end
	end

	// Slot-16 all-ones
	logic [3:0] s16_frame_reg; // Octet number in period
	logic [7:0] s16_zeros_reg; // Zeros so far in period
	logic s16_few_reg; // Previous period had few zeros
	logic [7:0] s16_total; // Zeros including this octet
	logic s16_few; // This period has few zeros

	assign s16_total = s16_zeros_reg + {4'h0, zeros8(rx_in.slot16_octet)};
	assign s16_few = s16_total < `E1RA_SLOT16_FEW;

	// Sixteen-frame periods of slot-16 zero counts
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			s16_frame_reg <= 4'h0;
			s16_zeros_reg <= 8'h00;
			s16_few_reg <= 1'b0;
			state_reg.slot16_allones <= 1'b0;
		end else if (rx_in.basic_aligned && rx_in.slot16_valid) begin
			s16_frame_reg <= s16_frame_reg + 4'h1;
			if (s16_frame_reg == `E1RA_AIS_FRAMES) begin
				s16_zeros_reg <= 8'h00;
				s16_few_reg <= s16_few;
				if (s16_few && s16_few_reg) begin
					state_reg.slot16_allones <= 1'b1;
				end else if (!s16_few) begin
					state_reg.slot16_allones <= 1'b0;
				end
			end else begin
				s16_zeros_reg <= s16_total;
			end
		end
	end

	// Remote multiframe alarm
	logic [1:0] yrun_reg; // Consecutive Y bits at one

	// Y bit runs under multiframe alignment
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			yrun_reg <= 2'h0;
			state_reg.remote_multiframe <= 1'b0;
		end else if (rx_in.mf_aligned && rx_in.y_valid) begin
			if (!rx_in.y_bit) begin
				yrun_reg <= 2'h0;
				state_reg.remote_multiframe <= 1'b0;
			end else begin
				if (yrun_reg != `E1RA_Y_RUN) begin
					yrun_reg <= yrun_reg + 2'h1;
				end
				if (yrun_reg == `E1RA_Y_RUN - 2'h1) begin
					state_reg.remote_multiframe <= 1'b1;
				end
			end
		end
	end

	// Line all-ones
	logic [8:0] win_pos_reg; // Bit position in window
	logic [1:0] win_zeros_reg; // Zeros seen, saturating
	logic win_few_reg; // Previous window had few zeros
	logic [1:0] win_total; // Zeros including this bit
	logic win_few; // This window has few zeros

	// Saturating zero count including the current bit
	always_comb begin
		if (!rx_in.line_bit && win_zeros_reg != `E1RA_WIN_FEW) begin
			win_total = win_zeros_reg + 2'h1;
		end else begin
			win_total = win_zeros_reg;
		end
	end

	assign win_few = win_total < `E1RA_WIN_FEW;

	// Fixed back-to-back 512-bit windows
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			win_pos_reg <= 9'h000;
			win_zeros_reg <= 2'h0;
			win_few_reg <= 1'b0;
			state_reg.allones <= 1'b0;
		end else if (rx_in.line_valid) begin
			win_pos_reg <= win_pos_reg + 9'h001;
			if (win_pos_reg == `E1RA_WIN_LAST) begin
				win_zeros_reg <= 2'h0;
				win_few_reg <= win_few;
				if (!allones_crit_reg) begin
					// Single window criterion
					if (win_few && !rx_in.basic_aligned) begin
						state_reg.allones <= 1'b1;
					end else if (!win_few) begin
						state_reg.allones <= 1'b0;
					end
				end else begin
					// Two window criterion
					if (win_few && win_few_reg) begin
						state_reg.allones <= 1'b1;
					end else if (!win_few && !win_few_reg) begin
						state_reg.allones <= 1'b0;
					end
				end
			end else begin
				win_zeros_reg <= win_total;
			end
		end
	end

	// Remote alarm
	logic [2:0] arun_reg; // Consecutive A bits at one

	// A bit runs under basic frame alignment
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			arun_reg <= 3'h0;
			state_reg.remote_alarm <= 1'b0;
		end else if (rx_in.basic_aligned && rx_in.a_valid) begin
			if (!rx_in.a_bit) begin
				arun_reg <= 3'h0;
				state_reg.remote_alarm <= 1'b0;
			end else begin
				if (arun_reg != `E1RA_A_RUN) begin
					arun_reg <= arun_reg + 3'h1;
				end
				if (remote_crit_reg) begin
					state_reg.remote_alarm <= 1'b1;
				end else if (arun_reg == `E1RA_A_RUN - 3'h1) begin
					state_reg.remote_alarm <= 1'b1;
				end
			end
		end
	end

	// Frame loss
	logic [23:0] red_cnt_reg; // Persistence counter

	// Count while alignment disagrees with the alarm
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			red_cnt_reg <= 24'h000000;
			state_reg.frame_loss <= 1'b0;
		end else if (rx_in.basic_aligned == state_reg.frame_loss) begin
			if (red_cnt_reg == RED_LAST) begin
				red_cnt_reg <= 24'h000000;
				// Declare when unaligned, clear when aligned
				state_reg.frame_loss <= !rx_in.basic_aligned;
			end else begin
				red_cnt_reg <= red_cnt_reg + 24'h000001;
			end
		end else begin
			red_cnt_reg <= 24'h000000;
		end
	end

	// Change flags
	// Previous states for edge detection
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			prev_reg <= `E1RA_RST_ALARM;
		end else begin
			prev_reg <= state_reg;
		end
	end

	// One sticky flag per alarm; a change wins over a clear
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_flag
			always_ff @(posedge sys_clk) begin
				if (!reset_n) begin
					flags_reg[gi] <= 1'b0;
				end else if (state_reg[gi] != prev_reg[gi]) begin
					flags_reg[gi] <= 1'b1;
				end else if (flag_clear[gi]) begin
					flags_reg[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// Control registers
	// Enable and criteria writes
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			irq_en_reg <= `E1RA_RST_ALARM;
			allones_crit_reg <= `E1RA_RST_CRIT;
			remote_crit_reg <= `E1RA_RST_CRIT;
		end else if (wr_lo) begin
			if (idx == `E1RA_IDX_IRQ_EN) begin
				irq_en_reg <= wb_dat_i[5:0];
			end
			if (idx == `E1RA_IDX_CRIT) begin
				allones_crit_reg <= wb_dat_i[`E1RA_BIT_ALLONES_CRIT];
				remote_crit_reg <= wb_dat_i[`E1RA_BIT_REMOTE_CRIT];
			end
		end
	end

	// Interrupt
	// Active-low request from enabled flags and other sources
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= !(|(flags_reg & irq_en_reg) || other_irq);
		end
	end

	// Bus slave
	// Read mux; reserved bits and unmapped indexes read zero
	always_comb begin
		case (idx)
			`E1RA_IDX_STATE: rd_byte = {2'h0, state_reg};
			`E1RA_IDX_IRQ_EN: rd_byte = {2'h0, irq_en_reg};
			`E1RA_IDX_FLAGS: rd_byte = {2'h0, flags_reg};
			`E1RA_IDX_CRIT: rd_byte = {2'h0, allones_crit_reg,
				remote_crit_reg, 4'h0};
			default: rd_byte = 8'h00;
		endcase
	end

	// One-wait-state acknowledge, dropped the next cycle
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i) begin
				wb_dat_o <= {24'h000000, rd_byte};
			end
		end
	end

endmodule // e1ra_alarm_detector
`default_nettype wire

// ==== e1ra_defines.svh ====
// Contract
// - Aligned: 16 zero slot-16 octets set loss
// - 16 nonzero slot-16 octets clear loss
// - Aligned: two periods under four zeros set all-ones
// - Over three zeros in one period clears all-ones
// - Three Y bits at one set multiframe alarm
// - One Y bit at zero clears multiframe alarm
// - Criterion zero: few zeros, unaligned declares
// - Criterion zero: over two zeros clears
// - Criterion one: two few-zero windows declare
// - Criterion one: two many-zero windows clear
// - Criterion zero: four A ones set remote
// - Criterion one: first A one sets remote
// - One A bit zero clears remote
// - Alignment lost 100 ms declares frame loss
// - Alignment held 100 ms clears frame loss
// - Flag latches on every state change
// - Flags clear by writing one only
// - Flag reaches interrupt only when enabled
// - Alarm registers reset zero, bits 7:6 reserved
// - Remote and frame loss changes latch too
// - Criteria register holds both selects, reset zero
`ifndef E1RA_DEFINES_SVH
`define E1RA_DEFINES_SVH

// Register indexes; byte address is index times four
`define E1RA_IDX_STATE 10'h0B9
`define E1RA_IDX_IRQ_EN 10'h0BA
`define E1RA_IDX_FLAGS 10'h0BB
`define E1RA_IDX_CRIT 10'h0BC

// Bit positions of the alarm fields and the criteria selects
`define E1RA_BIT_SLOT16_LOSS 5
`define E1RA_BIT_SLOT16_ALLONES 4
`define E1RA_BIT_REMOTE_MF 3
`define E1RA_BIT_ALLONES 2
`define E1RA_BIT_REMOTE 1
`define E1RA_BIT_FRAME_LOSS 0
`define E1RA_BIT_ALLONES_CRIT 5
`define E1RA_BIT_REMOTE_CRIT 4

// Reset values
`define E1RA_RST_ALARM 6'h00
`define E1RA_RST_CRIT 1'b0

// Detector thresholds
`define E1RA_SLOT16_RUN 5'd16
`define E1RA_AIS_FRAMES 4'd15
`define E1RA_SLOT16_FEW 8'd4
`define E1RA_Y_RUN 2'd3
`define E1RA_A_RUN 3'd4
`define E1RA_WIN_LAST 9'd511
`define E1RA_WIN_FEW 2'd3

// Frame-loss persistence time and its cycle count
`define E1RA_CLK_HZ 64'd100000000
`define E1RA_RED_TIME_MS 64'd100
`define E1RA_RED_CYCLES ((`E1RA_RED_TIME_MS * `E1RA_CLK_HZ) / 64'd1000)

`endif

// ==== e1ra_pkg.sv ====
package e1ra_pkg;

	// Alarm vector, bit 5 down to bit 0
	typedef struct packed {
		logic slot16_loss;
		logic slot16_allones;
		logic remote_multiframe;
		logic allones;
		logic remote_alarm;
		logic frame_loss;
	} e1ra_alarm_t;

	// Strobes and data from the receive framer
	typedef struct packed {
		logic basic_aligned;
		logic mf_aligned;
		logic line_valid;
		logic line_bit;
		logic slot16_valid;
		logic [7:0] slot16_octet;
		logic y_valid;
		logic y_bit;
		logic a_valid;
		logic a_bit;
	} e1ra_rx_t;

endpackage

// ==== e1ra_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "e1ra_defines.svh"
module e1ra_chk
	import e1ra_pkg::*;
#(
	parameter int unsigned RED_CYCLES = 20
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire e1ra_rx_t rx_in,
	input wire logic other_irq,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic irq_n
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// Request on the bus not yet answered
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// Read of an index outside the map
	sequence s_bad_rd;
		s_req ##0 (!wb_we_i && (wb_adr_i[11:2] < `E1RA_IDX_STATE
			|| wb_adr_i[11:2] > `E1RA_IDX_CRIT));
	endsequence
	a_ack_next:
		assert property (s_req |=> wb_ack_o) else $error("no ack");
	a_ack_pulse:
		assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	a_ack_cause:
		assert property (wb_ack_o |-> $past(wb_stb_i))
			else $error("ack without request");
	a_rsvd_zero:
		assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:6] == 26'h0)
			else $error("reserved bits set");
	a_unmap_zero:
		assert property (s_bad_rd |=> wb_dat_o == 32'h0)
			else $error("unmapped read not zero");
	a_wr_hold:
		assert property (wb_ack_o && wb_we_i |-> $stable(wb_dat_o))
			else $error("read data moved on write");
	a_irq_other:
		assert property (other_irq |=> !irq_n) else $error("irq missing");
	a_irq_reset:
		assert property ($rose(reset_n) |-> irq_n)
			else $error("irq after reset");
endmodule // e1ra_chk
bind e1ra_alarm_detector e1ra_chk #(.RED_CYCLES(RED_CYCLES)) u_chk (
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.rx_in(rx_in),
	.other_irq(other_irq),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.irq_n(irq_n)
);
`default_nettype wire

// ==== e1ra_framer_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module e1ra_framer_model
	import e1ra_pkg::*;
(
	input wire logic sys_clk,
	output var e1ra_rx_t rx_in
);
	// Aligned and idle at start
	initial rx_in = '{basic_aligned: 1'b1, mf_aligned: 1'b1, default: '0};
	// Alignment levels, changed just after an edge
	task automatic align(input logic b, input logic m);
		rx_in.basic_aligned <= b;
		rx_in.mf_aligned <= m;
	endtask
	// One strobe; gap 0 leaves it to the next strobe
	task automatic send(input int k, input logic [7:0] d, input int gap);
		rx_in.line_valid <= k == 0;
		rx_in.slot16_valid <= k == 1;
		rx_in.y_valid <= k == 2;
		rx_in.a_valid <= k == 3;
		rx_in.line_bit <= d[0];
		rx_in.y_bit <= d[0];
		rx_in.a_bit <= d[0];
		rx_in.slot16_octet <= d;
		@(posedge sys_clk);
		if (gap > 0) begin
			rx_in.line_valid <= 1'b0;
			rx_in.slot16_valid <= 1'b0;
			rx_in.y_valid <= 1'b0;
			rx_in.a_valid <= 1'b0;
			rx_in.line_bit <= ~d[0];
			rx_in.y_bit <= ~d[0];
			rx_in.a_bit <= ~d[0];
			rx_in.slot16_octet <= ~d;
			repeat (gap) @(posedge sys_clk);
		end
	endtask
endmodule // e1ra_framer_model
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "e1ra_defines.svh"
module tb
	import e1ra_pkg::*;
;
	localparam int RC = 20; // Short frame-loss time
	localparam logic [9:0] ST = `E1RA_IDX_STATE;
	localparam logic [9:0] EN = `E1RA_IDX_IRQ_EN;
	localparam logic [9:0] FL = `E1RA_IDX_FLAGS;
	localparam logic [9:0] CR = `E1RA_IDX_CRIT;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic other_irq = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [11:0] wb_adr = 12'h000;
	logic [3:0] wb_sel = 4'hF;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack;
	logic irq_n;
	e1ra_rx_t rx_in;
	logic [31:0] exp_q [$]; // Expected read data
	logic [31:0] seed = 32'h8A6F02A6;
	logic [7:0] s16_exp [5] = '{8'h20, 8'h00, 8'h10, 8'h20, 8'h00};
	logic [7:0] r;
	int error_cnt = 0;
	int num_checks = 0;
	always #5 sys_clk = ~sys_clk;
	e1ra_framer_model fr (.sys_clk(sys_clk), .rx_in(rx_in));
	e1ra_alarm_detector #(.RED_CYCLES(RC)) dut (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.rx_in(rx_in),
		.other_irq(other_irq),
		.wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb),
		.wb_we_i(wb_we),
		.wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel),
		.wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack),
		.irq_n(irq_n)
	);
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Idle gap of one to three cycles
	function automatic int gap();
		return 1 + int'(xs() % 3);
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Classic single cycle, held until ack
	task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= {i, 2'b00};
		wb_dat <= {24'h0, d};
		do @(posedge sys_clk); while (wb_ack !== 1'b1);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [9:0] i, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(1'b0, i, 8'h00);
	endtask
	task automatic ck_irq(input logic e);
		repeat (2) @(posedge sys_clk);
		check(irq_n, e);
	endtask
	// One 512-bit window, first z bits zero
	task automatic win(input int z);
		for (int i = 0; i < 512; i++)
			fr.send(0, {7'h0, i >= z}, i == 511);
	endtask
	// Compare each read answer with the oldest note
	always @(posedge sys_clk) begin
		if (wb_ack === 1'b1 && wb_we === 1'b0)
			check(wb_dat_o, exp_q.pop_front());
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		finish_test();
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 6; i++)
			rd(10'h0B8 + 10'(i), 8'h00);
		r = 8'(xs());
		bus(1'b1, EN, r);
		rd(EN, r & 8'h3F);
		// Write without lane 0 must be ignored
		wb_sel <= 4'(xs()) & 4'hE;
		bus(1'b1, EN, ~r);
		wb_sel <= 4'hF;
		rd(EN, r & 8'h3F);
		bus(1'b1, EN, 8'h3F);
		fr.align(1'b0, 1'b1);
		repeat (RC + 3) @(posedge sys_clk);
		rd(ST, 8'h01);
		ck_irq(1'b0);
		bus(1'b1, FL, 8'h00);
		rd(FL, 8'h01);
		bus(1'b1, FL, 8'h01);
		rd(FL, 8'h00);
		bus(1'b1, EN, 8'h3E);
		fr.align(1'b1, 1'b1);
		repeat (RC + 3) @(posedge sys_clk);
		rd(ST, 8'h00);
		rd(FL, 8'h01);
		ck_irq(1'b1);
		bus(1'b1, FL, 8'h01);
		other_irq <= 1'b1;
		ck_irq(1'b0);
		other_irq <= 1'b0;
		for (int k = 2; k < 4; k++) begin
			for (int n = 0; n <= k + 1; n++) begin
				rd(ST, n <= k ? 8'h00 : (k == 2 ? 8'h08 : 8'h02));
				if (n <= k)
					fr.send(k, 8'h01, gap());
			end
			fr.send(k, 8'h00, gap());
			rd(ST, 8'h00);
		end
		bus(1'b1, CR, 8'h10);
		rd(CR, 8'h10);
		fr.send(3, 8'h01, 1);
		rd(ST, 8'h02);
		fr.send(3, 8'h00, 1);
		rd(ST, 8'h00);
		for (int n = 0; n < 80; n++) begin
			fr.send(1, (n < 16 || (n >= 48 && n < 64)) ? 8'h00 : 8'hFF, gap());
			if (n == 14)
				rd(ST, 8'h00);
			if (n % 16 == 15)
				rd(ST, s16_exp[n / 16]);
		end
		win(2);
		rd(ST, 8'h00);
		fr.align(1'b0, 1'b1);
		// Slot-16 and A strobes ignored while unaligned
		for (int n = 0; n < 16; n++) begin
			fr.send(1, 8'h00, 1);
			fr.send(3, 8'h01, 1);
		end
		rd(ST, 8'h01);
		win(2);
		rd(ST, 8'h05);
		win(3);
		rd(ST, 8'h01);
		bus(1'b1, CR, 8'h20);
		fr.align(1'b1, 1'b1);
		for (int n = 0; n < 4; n++) begin
			win(n < 2 ? 2 : 3);
			rd(ST, (n == 0 || n == 3) ? 8'h00 : 8'h04);
		end
		rd(FL, 8'h3F);
		bus(1'b1, FL, 8'h2A);
		rd(FL, 8'h15);
		finish_test();
	end
endmodule // tb
`default_nettype wire
